// file: design/tpw_pkg.sv
// Overview of operation
// - Mode select 3 or 7 runs fast single-slope.
// - Fast top is 0xFF, or compare A.
// - Fast: clear on match, set at wrap.
// - Fast: counter at top clears next tick.
// - Fast: overflow flag set at top.
// - Codes 2/3 normal/inverted; code 1 toggles A when top is compare A.
// - Pin driven only when direction is output.
// - Fast period with top 0xFF: 256 ticks.
// - Fast compare extremes: spike or constant level.
// - Fast toggle gives 50% duty, buffered compare.
// - Select 1 or 5 counts up then down.
// - Phase: clear on up-match, set on down-match.
// - Phase: top held one tick, then reverses.
// - Phase: overflow flag set at zero.
// - Phase period with top 0xFF: 510 ticks.
// - Phase compare extremes give constant levels.
// - Phase output takes up-match level at top unless compare equals top.
// - Fully synchronous; tick is only an enable.
// - Reset clears both waveform output registers.
// - Action code zero leaves pin to port.
// - Counter write blocks matches for one tick.
// - Compare equal top with high bit: ignore match.
package tpw_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] TPW_OFF_CTRL = 8'h00;
  localparam logic [7:0] TPW_OFF_COUNT = 8'h04;
  localparam logic [7:0] TPW_OFF_CMPA = 8'h08;
  localparam logic [7:0] TPW_OFF_CMPB = 8'h0c;
  localparam logic [7:0] TPW_OFF_FLAGS = 8'h10;
  localparam logic [7:0] TPW_OFF_PORT = 8'h14;

  // Field positions.
  localparam int TPW_CTRL_MODE_LSB = 0;
  localparam int TPW_CTRL_ACTA_LSB = 4;
  localparam int TPW_CTRL_ACTB_LSB = 6;
  localparam int TPW_FLG_OVF = 0;
  localparam int TPW_FLG_MATA = 1;
  localparam int TPW_FLG_MATB = 2;
  localparam int TPW_FLG_WAVEA = 4;
  localparam int TPW_FLG_WAVEB = 5;
  localparam int TPW_FLG_DIRUP = 6;
  localparam int TPW_PORT_DIRA = 0;
  localparam int TPW_PORT_DIRB = 1;
  localparam int TPW_PORT_DATA = 2;
  localparam int TPW_PORT_DATB = 3;

  // Mode codes and limits.
  localparam logic [2:0] TPW_MODE_PHASE_FF = 3'h1;
  localparam logic [2:0] TPW_MODE_FAST_FF = 3'h3;
  localparam logic [2:0] TPW_MODE_PHASE_A = 3'h5;
  localparam logic [2:0] TPW_MODE_FAST_A = 3'h7;
  localparam logic [7:0] TPW_MAX = 8'hff;
  localparam logic [7:0] TPW_BOTTOM = 8'h00;
  localparam logic [1:0] TPW_ACT_OFF = 2'h0;
  localparam logic [1:0] TPW_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TPW_ACT_NONINV = 2'h2;
  localparam logic [1:0] TPW_ACT_INV = 2'h3;
  localparam logic [1:0] TPW_RESP_OKAY = 2'h0;
  localparam logic [1:0] TPW_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] actB;
    logic [1:0] actA;
    logic [2:0] mode;
  } tpw_ctrl_t;

  typedef struct packed {
    logic matB;
    logic matA;
    logic ovf;
  } tpw_flags_t;

endpackage : tpw_pkg

// file: design/tpw_timer_pwm.sv
`timescale 1ns/1ps
module tpw_timer_pwm
  import tpw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic timerTick,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pinOutA,
  output logic pinOeA,
  output logic pinOutB,
  output logic pinOeB
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tpw_ctrl_t ctrl_reg;
  tpw_flags_t flags_reg;
  logic [7:0] count_reg;
  logic [7:0] cmpABuf_reg;
  logic [7:0] cmpBBuf_reg;
  logic [7:0] cmpAAct_reg;
  logic [7:0] cmpBAct_reg;
  logic [3:0] port_reg;
  logic waveA_reg;
  logic waveB_reg;
  logic dirUp_reg;
  logic blockMatch_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic awHave_reg;
  logic wHave_reg;

  // ----------------------------------------------------------------
  // Bus write path
  // ----------------------------------------------------------------
  logic doWrite;
  logic wrLane;
  logic wrCount;
  logic wrMapped;
  assign doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;
  assign wrLane = doWrite && wStrb_reg[0];
  assign wrCount = wrLane && (awAddr_reg == TPW_OFF_COUNT);
  assign wrMapped = (awAddr_reg == TPW_OFF_CTRL) || (awAddr_reg == TPW_OFF_COUNT) ||
                    (awAddr_reg == TPW_OFF_CMPA) || (awAddr_reg == TPW_OFF_CMPB) ||
                    (awAddr_reg == TPW_OFF_FLAGS) || (awAddr_reg == TPW_OFF_PORT);

  // Address and data are taken in either order and held until the write is done.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TPW_RESP_OKAY;
    end else begin
      s_axi_awready <= !awHave_reg && !s_axi_awready && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHave_reg && !s_axi_wready && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHave_reg <= 1'b0;
        wHave_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? TPW_RESP_OKAY : TPW_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus read path
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= TPW_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= TPW_RESP_OKAY;
        unique case (s_axi_araddr)
          TPW_OFF_CTRL: s_axi_rdata <= {24'h0, ctrl_reg.actB, ctrl_reg.actA, 1'b0,
                                        ctrl_reg.mode};
          TPW_OFF_COUNT: s_axi_rdata <= {24'h0, count_reg};
          TPW_OFF_CMPA: s_axi_rdata <= {24'h0, cmpABuf_reg};
          TPW_OFF_CMPB: s_axi_rdata <= {24'h0, cmpBBuf_reg};
          TPW_OFF_FLAGS: s_axi_rdata <= {25'h0, dirUp_reg, waveB_reg, waveA_reg, 1'b0,
                                         flags_reg};
          TPW_OFF_PORT: s_axi_rdata <= {28'h0, port_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= TPW_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode decode and compare
  // ----------------------------------------------------------------
  logic fastMode;
  logic phaseMode;
  logic pwmMode;
  logic [7:0] topVal;
  logic atTop;
  logic atBottom;
  logic hitA;
  logic hitB;
  logic matchA;
  logic matchB;
  logic upEdge;
  logic toggleA;
  assign fastMode = (ctrl_reg.mode == TPW_MODE_FAST_FF) ||
                    (ctrl_reg.mode == TPW_MODE_FAST_A);
  assign phaseMode = (ctrl_reg.mode == TPW_MODE_PHASE_FF) ||
                     (ctrl_reg.mode == TPW_MODE_PHASE_A);
  assign pwmMode = fastMode || phaseMode;
  assign topVal = ctrl_reg.mode[2] ? cmpAAct_reg : TPW_MAX;
  assign atTop = count_reg == topVal;
  assign atBottom = count_reg == TPW_BOTTOM;
  // The tick is only an enable; a blocked tick follows any counter write.
  assign hitA = timerTick && (count_reg == cmpAAct_reg) && !blockMatch_reg;
  assign hitB = timerTick && (count_reg == cmpBAct_reg) && !blockMatch_reg;
  // A match at top with the high action bit set is dropped; top handles it.
  assign matchA = hitA && !(pwmMode && atTop && ctrl_reg.actA[1]);
  assign matchB = hitB && !(pwmMode && atTop && ctrl_reg.actB[1]);
  // At bottom the slope turns upward, so a match there counts as up-counting.
  assign upEdge = dirUp_reg || atBottom;
  assign toggleA = ctrl_reg.mode[2] && (ctrl_reg.actA == TPW_ACT_TOGGLE);

  // ----------------------------------------------------------------
  // Control and compare registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_reg <= '0;
      port_reg <= 4'h0;
      cmpABuf_reg <= 8'h00;
      cmpBBuf_reg <= 8'h00;
      cmpAAct_reg <= 8'h00;
      cmpBAct_reg <= 8'h00;
    end else begin
      if (wrLane && awAddr_reg == TPW_OFF_CTRL) begin
        ctrl_reg.mode <= wData_reg[TPW_CTRL_MODE_LSB +: 3];
        ctrl_reg.actA <= wData_reg[TPW_CTRL_ACTA_LSB +: 2];
        ctrl_reg.actB <= wData_reg[TPW_CTRL_ACTB_LSB +: 2];
      end
      if (wrLane && awAddr_reg == TPW_OFF_PORT) begin
        port_reg <= wData_reg[3:0];
      end
      if (wrLane && awAddr_reg == TPW_OFF_CMPA) begin
        cmpABuf_reg <= wData_reg[7:0];
      end
      if (wrLane && awAddr_reg == TPW_OFF_CMPB) begin
        cmpBBuf_reg <= wData_reg[7:0];
      end
      // Outside the waveform modes the buffers act as wires.
      if (!pwmMode || (timerTick && atTop)) begin
        cmpAAct_reg <= cmpABuf_reg;
        cmpBAct_reg <= cmpBBuf_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_reg <= 8'h00;
      dirUp_reg <= 1'b1;
      blockMatch_reg <= 1'b0;
    end else begin
      if (wrCount) begin
        blockMatch_reg <= 1'b1;
      end else if (timerTick) begin
        blockMatch_reg <= 1'b0;
      end
      if (wrCount) begin
        count_reg <= wData_reg[7:0];
      end else if (timerTick) begin
        if (phaseMode) begin
          // Top and bottom are each held for one tick, giving 2*top ticks a period.
          if (dirUp_reg && atTop) begin
            dirUp_reg <= 1'b0;
            count_reg <= atBottom ? TPW_BOTTOM : count_reg - 8'h01;
          end else if (!dirUp_reg && atBottom) begin
            dirUp_reg <= 1'b1;
            count_reg <= atTop ? TPW_BOTTOM : count_reg + 8'h01;
          end else begin
            count_reg <= dirUp_reg ? count_reg + 8'h01 : count_reg - 8'h01;
          end
        end else begin
          dirUp_reg <= 1'b1;
          // Fast mode clears at top; 0xFF as top gives 256 ticks a period.
          count_reg <= (fastMode && atTop) ? TPW_BOTTOM : count_reg + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags, write one to clear; a set in the same cycle wins
  // ----------------------------------------------------------------
  tpw_flags_t flagSet;
  tpw_flags_t flagClr;
  always_comb begin
    flagSet.ovf = timerTick && (fastMode ? atTop : (phaseMode ? atBottom :
                  (count_reg == TPW_MAX)));
    flagSet.matA = hitA;
    flagSet.matB = hitB;
    flagClr = (wrLane && awAddr_reg == TPW_OFF_FLAGS) ? tpw_flags_t'(wData_reg[2:0]) : '0;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flagSet | (flags_reg & ~flagClr);
    end
  end

  // ----------------------------------------------------------------
  // Waveform output registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      waveA_reg <= 1'b0;
    end else if (timerTick && fastMode) begin
      if (ctrl_reg.actA[1] && atTop) begin
        waveA_reg <= !ctrl_reg.actA[0];
      end else if (ctrl_reg.actA[1] && matchA) begin
        waveA_reg <= ctrl_reg.actA[0];
      end else if (toggleA && matchA) begin
        waveA_reg <= !waveA_reg;
      end
    end else if (timerTick && phaseMode) begin
      if (ctrl_reg.actA[1] && dirUp_reg && atTop) begin
        // Compare at top keeps the down level; otherwise force the up level.
        waveA_reg <= (cmpAAct_reg == topVal) ? !ctrl_reg.actA[0] : ctrl_reg.actA[0];
      end else if (ctrl_reg.actA[1] && matchA) begin
        waveA_reg <= upEdge ? ctrl_reg.actA[0] : !ctrl_reg.actA[0];
      end else if (toggleA && matchA) begin
        waveA_reg <= !waveA_reg;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      waveB_reg <= 1'b0;
    end else if (timerTick && fastMode && ctrl_reg.actB[1]) begin
      if (atTop) begin
        waveB_reg <= !ctrl_reg.actB[0];
      end else if (matchB) begin
        waveB_reg <= ctrl_reg.actB[0];
      end
    end else if (timerTick && phaseMode && ctrl_reg.actB[1]) begin
      if (dirUp_reg && atTop) begin
        waveB_reg <= (cmpBAct_reg == topVal) ? !ctrl_reg.actB[0] : ctrl_reg.actB[0];
      end else if (matchB) begin
        waveB_reg <= upEdge ? ctrl_reg.actB[0] : !ctrl_reg.actB[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // The waveform only overrides the port data; the driver follows direction alone.
  logic connA;
  logic connB;
  assign connA = ctrl_reg.actA[1] || (toggleA && pwmMode);
  assign connB = ctrl_reg.actB[1];
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pinOutA <= 1'b0;
      pinOutB <= 1'b0;
      pinOeA <= 1'b0;
      pinOeB <= 1'b0;
    end else begin
      pinOutA <= connA ? waveA_reg : port_reg[TPW_PORT_DATA];
      pinOutB <= connB ? waveB_reg : port_reg[TPW_PORT_DATB];
      pinOeA <= port_reg[TPW_PORT_DIRA];
      pinOeB <= port_reg[TPW_PORT_DIRB];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  fast_wrap_a: assert property (timerTick && fastMode && atTop && !wrCount |=>
      count_reg == 8'h00)
    else $error("fast counter did not clear after top");
  fast_ovf_a: assert property (timerTick && fastMode && atTop |=> flags_reg.ovf)
    else $error("fast overflow flag missing at top");
  phase_rev_a: assert property (timerTick && phaseMode && dirUp_reg && atTop &&
      !atBottom && !wrCount |=> !dirUp_reg && count_reg == $past(count_reg) - 8'h01)
    else $error("phase counter did not reverse after top");
  phase_ovf_a: assert property (timerTick && phaseMode && atBottom |=> flags_reg.ovf)
    else $error("phase overflow flag missing at bottom");
  match_block_a: assert property (timerTick && blockMatch_reg && !flags_reg.matA
      |=> !flags_reg.matA)
    else $error("match not blocked after counter write");
  match_flag_a: assert property (hitA |=> flags_reg.matA)
    else $error("match flag A not set");
  fast_set_a: assert property (timerTick && fastMode && atTop &&
      ctrl_reg.actA == TPW_ACT_NONINV |=> waveA_reg)
    else $error("fast output not set at wrap");
  phase_up_a: assert property (timerTick && phaseMode && dirUp_reg && matchA &&
      !atTop && ctrl_reg.actA == TPW_ACT_NONINV |=> !waveA_reg)
    else $error("phase up match did not clear output");
  buf_copy_a: assert property (timerTick && pwmMode && atTop |=>
      cmpAAct_reg == $past(cmpABuf_reg))
    else $error("compare buffer not copied at top");
  pin_dir_a: assert property (##1 pinOeA == $past(port_reg[TPW_PORT_DIRA]))
    else $error("pin enable not following direction");
  pin_off_a: assert property (ctrl_reg.actA == TPW_ACT_OFF |=>
      pinOutA == $past(port_reg[TPW_PORT_DATA]))
    else $error("disconnected pin not under port control");
  wave_rst_a: assert property (@(posedge ref_clk) disable iff (1'b0)
      srst |=> !waveA_reg && !waveB_reg)
    else $error("waveform registers not cleared by reset");

  fast_wrap_c: cover property (timerTick && fastMode && atTop ##1 count_reg == 8'h00);
  phase_rev_c: cover property (timerTick && phaseMode && dirUp_reg && atTop);
  cnt_block_c: cover property (wrCount ##1 timerTick && blockMatch_reg);
  toggle_c: cover property (timerTick && toggleA && matchA);
  phase_b_c: cover property (timerTick && phaseMode && matchB);

endmodule : tpw_timer_pwm

// file: verif/tpw_timer_pwm_bench.sv
`timescale 1ns/1ps
module tpw_timer_pwm_bench;
  import tpw_pkg::*;
  // ----------------------------------------------------------------
  // Signals and notes
  // ----------------------------------------------------------------
  typedef struct {string name; logic [31:0] data; logic [31:0] mask; logic [1:0] resp;} tpw_note_t;
  typedef struct {logic [2:0] mode; logic [1:0] act; logic [7:0] cmp;
                  int div; int hi; int per;} tpw_case_t;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic timerTick = 1'b0;
  logic [7:0] awAddr = 8'h00;
  logic awValid = 1'b0;
  logic awReady;
  logic [31:0] wData = 32'h0;
  logic wValid = 1'b0;
  logic wReady;
  logic [1:0] bResp;
  logic bValid;
  logic bReady = 1'b0;
  logic [7:0] arAddr = 8'h00;
  logic arValid = 1'b0;
  logic arReady;
  logic [31:0] rData;
  logic [1:0] rResp;
  logic rValid;
  logic rReady = 1'b0;
  logic pinOutA, pinOeA, pinOutB, pinOeB;
  tpw_note_t rdQ[$];
  logic [1:0] wrQ[$];
  tpw_note_t note;
  int mismatches = 0;
  int nChecks = 0;
  int tickDiv = 0;
  int tickCnt = 0;
  int seed = 32'h289c;

  tpw_timer_pwm tpw_timer_pwm_inst (.ref_clk(ref_clk), .srst(srst), .timerTick(timerTick),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .pinOutA(pinOutA), .pinOeA(pinOeA), .pinOutB(pinOutB), .pinOeB(pinOeB));

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // A divider of zero stops the tick; one holds it high for no prescale.
  always @(posedge ref_clk) begin
    tickCnt <= (tickCnt + 1 >= tickDiv) ? 0 : tickCnt + 1;
    timerTick <= (tickDiv != 0) && (tickCnt == 0);
  end

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  always @(posedge ref_clk) begin
    if (rValid === 1'b1 && rReady && rdQ.size() > 0) begin
      note = rdQ.pop_front();
      check(note.name, note.data, rData & note.mask);
      check("rresp", {30'h0, note.resp}, {30'h0, rResp});
    end
    if (bValid === 1'b1 && bReady && wrQ.size() > 0) begin
      check("bresp", {30'h0, wrQ.pop_front()}, {30'h0, bResp});
    end
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    $display("BAD run length expected end seen timeout");
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Bus and pin tasks
  // ----------------------------------------------------------------
  task automatic bus_timeout(input string what);
    mismatches++;
    $display("BAD %s expected answer seen none", what);
    wrap_up();
  endtask : bus_timeout

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    wrQ.push_back(r);
    @(posedge ref_clk);
    awAddr <= a;
    awValid <= 1'b1;
    wData <= d;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awValid && awReady === 1'b1) awValid <= 1'b0;
      if (wValid && wReady === 1'b1) wValid <= 1'b0;
      n++;
      if (n > 200) bus_timeout("write");
    end while (bValid !== 1'b1);
    bReady <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input string nm, input logic [7:0] a, input logic [31:0] d,
                          input logic [31:0] m, input logic [1:0] r);
    int n;
    n = 0;
    rdQ.push_back('{nm, d, m, r});
    @(posedge ref_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arValid && arReady === 1'b1) arValid <= 1'b0;
      n++;
      if (n > 200) bus_timeout("read");
    end while (rValid !== 1'b1);
    rReady <= 1'b0;
  endtask : axi_read

  task automatic wait_level(input logic lvl, output int cnt);
    cnt = 0;
    while (pinOutA !== lvl) begin
      @(posedge ref_clk);
      cnt++;
      if (cnt > 10000) bus_timeout("pinOutA level");
    end
  endtask : wait_level

  // The first periods after a change are thrown away while the compare buffer settles.
  task automatic measure(output int hi, output int per);
    int t, lo;
    repeat (2) begin
      wait_level(1'b0, t);
      wait_level(1'b1, t);
    end
    wait_level(1'b0, hi);
    wait_level(1'b1, lo);
    per = hi + lo;
  endtask : measure

  task automatic flag_cycle();
    tickDiv <= 0;
    axi_read("flags set", TPW_OFF_FLAGS, 32'h7, 32'h7, TPW_RESP_OKAY);
    axi_write(TPW_OFF_FLAGS, 32'h7, TPW_RESP_OKAY);
    axi_read("flags cleared", TPW_OFF_FLAGS, 32'h0, 32'h7, TPW_RESP_OKAY);
  endtask : flag_cycle

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  tpw_case_t cases [0:12] = '{
    '{3'h3, 2'h2, 8'h00, 1, 0, 256},
    '{3'h3, 2'h3, 8'h40, 1, 191, 256},
    '{3'h3, 2'h2, 8'h00, 1, 1, 256},
    '{3'h3, 2'h2, 8'h40, 8, 520, 2048},
    '{3'h7, 2'h1, 8'h03, 1, 4, 8},
    '{3'h7, 2'h1, 8'h00, 1, 1, 2},
    '{3'h1, 2'h2, 8'h40, 1, 128, 510},
    '{3'h1, 2'h3, 8'h40, 1, 382, 510},
    '{3'h5, 2'h1, 8'h03, 1, 6, 12},
    '{3'h3, 2'h2, 8'hff, 1, 1, 0},
    '{3'h1, 2'h2, 8'h00, 1, 0, 0},
    '{3'h1, 2'h2, 8'hff, 1, 1, 0},
    '{3'h1, 2'h3, 8'h00, 1, 1, 0}};

  initial begin
    tpw_case_t c;
    int i, hi, per, bad, badB;
    logic [7:0] cmpR;
    cmpR = 8'h01 + 8'($unsigned($random(seed)) % 254);
    cases[0].cmp = cmpR;
    cases[0].hi = int'(cmpR) + 1;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    axi_read("ctrl reset", TPW_OFF_CTRL, 32'h0, 32'hffffffff, TPW_RESP_OKAY);
    // The direction bit reads as up after reset; the waveform bits read clear.
    axi_read("flags reset", TPW_OFF_FLAGS, 32'h40, 32'hffffffff, TPW_RESP_OKAY);
    axi_read("unmapped", 8'h20, 32'h0, 32'hffffffff, TPW_RESP_SLVERR);
    axi_write(8'h20, 32'h1, TPW_RESP_SLVERR);
    axi_write(TPW_OFF_COUNT, 32'h5a, TPW_RESP_OKAY);
    axi_read("count", TPW_OFF_COUNT, 32'h5a, 32'hffffffff, TPW_RESP_OKAY);
    axi_write(TPW_OFF_PORT, 32'h5, TPW_RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    check("port pin A", 32'h3, {30'h0, pinOeA, pinOutA});
    check("port pin B", 32'h0, {30'h0, pinOeB, pinOutB});
    // Counting starts on the compare value, then one below it: only the second may match.
    axi_write(TPW_OFF_CMPA, 32'h5a, TPW_RESP_OKAY);
    for (i = 0; i < 2; i++) begin
      axi_write(TPW_OFF_COUNT, 32'h5a - i, TPW_RESP_OKAY);
      tickDiv <= 1;
      repeat (10) @(posedge ref_clk);
      tickDiv <= 0;
      axi_read("count block", TPW_OFF_FLAGS, 32'(i) << 1, 32'h2, TPW_RESP_OKAY);
    end
    axi_write(TPW_OFF_PORT, 32'h3, TPW_RESP_OKAY);
    for (i = 0; i < 13; i++) begin
      c = cases[i];
      tickDiv <= 0;
      axi_write(TPW_OFF_COUNT, 32'h0, TPW_RESP_OKAY);
      axi_write(TPW_OFF_CMPA, {24'h0, c.cmp}, TPW_RESP_OKAY);
      axi_write(TPW_OFF_CTRL, {24'h0, 2'h2, c.act, 1'b0, c.mode}, TPW_RESP_OKAY);
      tickDiv <= c.div;
      if (c.per == 0) begin
        repeat (1100) @(posedge ref_clk);
        bad = 0;
        badB = 0;
        repeat (600) begin
          @(posedge ref_clk);
          if (pinOutA !== c.hi[0]) bad++;
          if (pinOutB !== 1'b0) badB++;
        end
        check("steady misses", 32'h0, 32'(bad));
        // Compare B stays at zero, so a non-inverted phase output B stays low.
        if (c.mode == TPW_MODE_PHASE_FF) check("steady B misses", 32'h0, 32'(badB));
      end else begin
        measure(hi, per);
        check("high time", 32'(c.hi), 32'(hi));
        check("period", 32'(c.per), 32'(per));
      end
      if (i == 0) flag_cycle();
      if (i == 6) flag_cycle();
    end
    wrap_up();
  end
endmodule : tpw_timer_pwm_bench
